// *** shared/sls_pkg.sv ***
/*
  Constants of the signal limit supervisor: register map, fields,
  reset values, mode and action codes, event codes, timing.
  Assumes a 125 MHz system clock and 32-bit AHB-Lite data.
*/
package sls_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int FILT_UNIT_NS  = 1000000;  // One filter count, 1 ms
  localparam int TICK_CYCLES   = (FILT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------
  localparam logic [7:0] CH_STRIDE   = 8'h20;  // Channel 1 block base
  localparam logic [4:0] OFF_CTRL    = 5'h00;
  localparam logic [4:0] OFF_FILT    = 5'h04;
  localparam logic [4:0] OFF_LOW     = 5'h08;
  localparam logic [4:0] OFF_HIGH    = 5'h0C;
  localparam logic [4:0] OFF_HYST    = 5'h10;
  localparam logic [4:0] OFF_VALUE   = 5'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h40;
  localparam logic [7:0] ADDR_EVENT  = 8'h44;
  localparam logic [7:0] ADDR_MASK   = 8'h48;
  localparam logic [7:0] ADDR_FAULT  = 8'h4C;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int FUNC_LSB = 0;  // [2:0]
  localparam int ACT_LSB  = 4;  // [5:4]
  localparam int EV_WARN  = 0;  // Event bits [1:0] warnings
  localparam int EV_FAULT = 2;  // Event bits [3:2] faults
  // ----------------------------------------
  // Modes and actions
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF      = 3'h0,
    MODE_LOW      = 3'h1,
    MODE_HIGH     = 3'h2,
    MODE_ABS_LOW  = 3'h3,
    MODE_ABS_HIGH = 3'h4,
    MODE_BOTH     = 3'h5,
    MODE_ABS_BOTH = 3'h6
  } sup_mode_e;
  typedef enum logic [1:0] {
    ACT_NONE  = 2'h0,
    ACT_WARN  = 2'h1,
    ACT_FAULT = 2'h2
  } sup_act_e;
  // ----------------------------------------
  // Reset values, ranges, codes
  // ----------------------------------------
  localparam logic [15:0] RST_TC     = 16'h0000;
  localparam logic [31:0] RST_LIMIT  = 32'h0000_0000;
  localparam logic [31:0] RST_HYST   = 32'h0000_0000;
  localparam logic [3:0]  RST_MASK   = 4'h0;
  localparam logic [15:0] TC_MAX     = 16'h7530;       // 30.000 s
  localparam logic [31:0] LIMIT_MAX  = 32'h7FFF_FFD0;  // +21474836.00
  localparam logic [31:0] LIMIT_MIN  = 32'h8000_0030;  // -21474836.00
  localparam logic [31:0] HYST_MAX   = 32'h0098_9680;  // 100000.00
  localparam logic [15:0] WARN_CODE0  = 16'hA8B2;
  localparam logic [15:0] FAULT_CODE0 = 16'h80B2;
  localparam logic [15:0] WARN_CODE1  = 16'hA8B3;
  localparam logic [15:0] FAULT_CODE1 = 16'h80B3;
endpackage

// *** logic/sup_channel.sv ***
/*
  One supervision channel: first-order filter of the monitored value
  and limit comparison with hysteresis in the selected mode.
  Assumes the value comes from logic on the same clock and the tick is
  a one-cycle pulse every filter count (1 ms).
*/
`timescale 1ns/10ps
module sup_channel (
  // Clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_rst_n,
  // Filter tick and monitored value (hundredths)
  input  wire logic               i_tick,
  input  wire logic signed [31:0] i_value,
  // Settings
  input  wire logic [2:0]         i_mode,
  input  wire logic [15:0]        i_tc,
  input  wire logic signed [31:0] i_low,
  input  wire logic signed [31:0] i_high,
  input  wire logic [31:0]        i_hyst,
  // Results
  output logic signed [31:0]      o_filtered,
  output logic                    o_cond
);
  // ----------------------------------------
  // Filter
  // ----------------------------------------
  // Shift from the time constant: a power-of-two step keeps the
  // filter free of a divider, at the cost of a coarse time constant.
  function automatic logic [3:0] tc_shift(input logic [15:0] tc);
    logic [3:0] s;
    s = 4'h0;
    for (int b = 1; b < 16; b++) begin
      if (tc[b]) s = 4'(b);
    end
    return s;
  endfunction

  logic signed [32:0] diff;   // Input minus state
  logic signed [32:0] step;   // Scaled correction
  logic signed [32:0] sum;    // New state, wide
  assign diff = {i_value[31], i_value} - {o_filtered[31], o_filtered};
  assign step = diff >>> tc_shift(i_tc);
  assign sum  = {o_filtered[31], o_filtered} + step;

  // Zero time constant passes the value straight through
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_filtered <= 32'sh0;
    end else if (i_tc == 16'h0000) begin
      o_filtered <= i_value;  // see RQ19
    end else if (i_tick) begin
      o_filtered <= sum[31:0];  // see RQ12 see RQ19
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic watch_low;   // Lower limit in use
  logic watch_high;  // Upper limit in use
  logic use_abs;     // Compare magnitudes
  always_comb begin
    watch_low  = 1'b0;
    watch_high = 1'b0;
    use_abs    = 1'b0;
    unique case (i_mode)
      sls_pkg::MODE_OFF: ;  // see RQ1
      sls_pkg::MODE_LOW: watch_low = 1'b1;  // see RQ2
      sls_pkg::MODE_HIGH: watch_high = 1'b1;  // see RQ3
      sls_pkg::MODE_ABS_LOW: begin  // see RQ4
        watch_low = 1'b1;
        use_abs   = 1'b1;
      end
      sls_pkg::MODE_ABS_HIGH: begin  // see RQ5
        watch_high = 1'b1;
        use_abs    = 1'b1;
      end
      sls_pkg::MODE_BOTH: begin  // see RQ6
        watch_low  = 1'b1;
        watch_high = 1'b1;
      end
      sls_pkg::MODE_ABS_BOTH: begin  // see RQ7
        watch_low  = 1'b1;
        watch_high = 1'b1;
        use_abs    = 1'b1;
      end
      default: ;  // Code 7 is illegal and acts as unused
    endcase
  end

  // ----------------------------------------
  // Comparison with hysteresis
  // ----------------------------------------
  // 34-bit signed so that magnitudes and limit plus hysteresis fit
  function automatic logic signed [33:0] ext(input logic signed [31:0] v,
                                             input logic mag);
    ext = (mag && v < 0) ? -34'(v) : 34'(v);
  endfunction

  logic signed [33:0] val_c;  // Compared value
  logic signed [33:0] low_c;  // Lower reference
  logic signed [33:0] high_c; // Upper reference
  logic signed [33:0] hyst_c; // Hysteresis
  assign val_c  = ext(o_filtered, use_abs);
  assign low_c  = ext(i_low, use_abs);
  assign high_c = ext(i_high, use_abs);
  assign hyst_c = {2'b00, i_hyst};

  logic low_r;   // Below-limit held
  logic high_r;  // Above-limit held
  logic low_nxt;
  logic high_nxt;
  // Once hit, stay until back past the limit by the hysteresis
  assign low_nxt  = watch_low & (low_r ? (val_c < low_c + hyst_c)  // see RQ18
                                       : (val_c < low_c));
  assign high_nxt = watch_high & (high_r ? (val_c > high_c - hyst_c)  // see RQ18
                                         : (val_c > high_c));

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      low_r  <= 1'b0;
      high_r <= 1'b0;
      o_cond <= 1'b0;
    end else begin
      low_r  <= low_nxt;
      high_r <= high_nxt;
      o_cond <= low_nxt | high_nxt;
    end
  end
endmodule

// *** logic/signal_limit_supervisor.sv ***
/*
  Signal limit supervisor: two supervision channels with settings over
  AHB-Lite, warning and fault outputs with event codes, and a maskable
  interrupt. Assumes monitored values arrive from logic on i_clock as
  signed hundredths, and one AHB-Lite master with this sole slave.
*/
`timescale 1ns/10ps

// How it works
// RQ1: Function code 0 means channel unused
// RQ2: Code 1 acts below the lower limit
// RQ3: Code 2 acts above the upper limit
// RQ4: Code 3 acts when magnitude under lower magnitude
// RQ5: Code 4 acts when magnitude over upper magnitude
// RQ6: Code 5 acts outside signed low/high window
// RQ7: Code 6 acts outside magnitude low/high window
// RQ8: Action 0 raises neither warning nor fault
// RQ9: Action 1 raises warning with code A8B2
// RQ10: Action 2 trips fault with code 80B2
// RQ11: Status never depends on the action
// RQ12: Filter time 0 to 30 s, ms counts
// RQ13: Signed lower limit, clamped range, reset zero
// RQ14: Signed upper limit, clamped range, reset zero
// RQ15: Non-negative hysteresis, reset zero
// RQ16: Reset gives function disabled, action none
// RQ17: Second identical channel, same mode codes
// RQ18: Hit holds until back past hysteresis
// RQ19: First-order filter, zero passes value through
module signal_limit_supervisor #(
  parameter int TICK_CYCLES = sls_pkg::TICK_CYCLES  // Cycles per filter count
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Monitored values
  input  wire logic [31:0] i_value0,
  input  wire logic [31:0] i_value1,
  // Supervision results
  output logic [1:0]       o_status,
  output logic             o_warning,
  output logic [15:0]      o_warn_code,
  output logic             o_fault,
  output logic [15:0]      o_fault_code,
  output logic             o_irq
);
  // ----------------------------------------
  // Filter tick
  // ----------------------------------------
  logic [31:0] tick_cnt_r;  // Cycles into the count
  logic        tick_r;      // One-cycle pulse per ms
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r     <= 1'b0;
    end
  end

  // ----------------------------------------
  // AHB address phase
  // ----------------------------------------
  // Only the low byte decodes; anything above it is unmapped
  logic       addr_take;   // Transfer accepted
  logic       addr_high0;  // Upper address bits clear
  logic [7:0] a_lo;        // Low address byte
  assign addr_take  = i_hsel & i_htrans[1] & i_hready;
  assign addr_high0 = (i_haddr[31:8] == 24'h00_0000);
  assign a_lo       = i_haddr[7:0];

  logic       wr_pend_r;  // Write data phase pending
  logic [7:0] wr_addr_r;  // Its address
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_take & i_hwrite & addr_high0;
      wr_addr_r <= a_lo;
    end
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [2:0]  func_r [2];  // Function selectors
  logic [1:0]  act_r  [2];  // Action selectors
  logic [15:0] tc_r   [2];  // Filter time, ms
  logic [31:0] low_r  [2];  // Lower limits
  logic [31:0] high_r [2];  // Upper limits
  logic [31:0] hyst_r [2];  // Hysteresis
  logic [3:0]  event_r;     // Sticky events
  logic [3:0]  mask_r;      // Interrupt mask
  logic [1:0]  fault_r;     // Tripped faults
  logic [1:0]  warn_prev_r; // Warning levels last cycle

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  logic        wr_ch_hit;  // Into a channel block
  logic        wr_ch;      // Which channel
  logic [4:0]  wr_off;     // Offset within block
  logic [31:0] wd;         // Write data
  assign wr_ch_hit = wr_pend_r & (wr_addr_r[7:6] == 2'b00);
  assign wr_ch     = wr_addr_r[5];
  assign wr_off    = wr_addr_r[4:0];
  assign wd        = i_hwdata;

  logic wr_ctrl;
  logic wr_filt;
  logic wr_low;
  logic wr_high;
  logic wr_hyst;
  logic wr_event;
  logic wr_mask;
  logic wr_fault;
  assign wr_ctrl  = wr_ch_hit & (wr_off == sls_pkg::OFF_CTRL);
  assign wr_filt  = wr_ch_hit & (wr_off == sls_pkg::OFF_FILT);
  assign wr_low   = wr_ch_hit & (wr_off == sls_pkg::OFF_LOW);
  assign wr_high  = wr_ch_hit & (wr_off == sls_pkg::OFF_HIGH);
  assign wr_hyst  = wr_ch_hit & (wr_off == sls_pkg::OFF_HYST);
  assign wr_event = wr_pend_r & (wr_addr_r == sls_pkg::ADDR_EVENT);
  assign wr_mask  = wr_pend_r & (wr_addr_r == sls_pkg::ADDR_MASK);
  assign wr_fault = wr_pend_r & (wr_addr_r == sls_pkg::ADDR_FAULT);

  // Written values clamped to their ranges
  logic [15:0] tc_in;
  logic [31:0] lim_in;
  logic [31:0] hyst_in;
  assign tc_in   = (wd[31:16] != 16'h0000 || wd[15:0] > sls_pkg::TC_MAX) ?
                   sls_pkg::TC_MAX : wd[15:0];
  assign lim_in  = ($signed(wd) > $signed(sls_pkg::LIMIT_MAX)) ? sls_pkg::LIMIT_MAX :
                   ($signed(wd) < $signed(sls_pkg::LIMIT_MIN)) ? sls_pkg::LIMIT_MIN : wd;
  assign hyst_in = wd[31] ? 32'h0000_0000 :
                   (wd > sls_pkg::HYST_MAX) ? sls_pkg::HYST_MAX : wd;

  // Channel settings; reset leaves both channels disabled
  always_ff @(posedge i_clock) begin
    for (int c = 0; c < 2; c++) begin
      if (!i_rst_n) begin
        func_r[c] <= sls_pkg::MODE_OFF;  // see RQ16 see RQ17
        act_r[c]  <= sls_pkg::ACT_NONE;  // see RQ16
        tc_r[c]   <= sls_pkg::RST_TC;  // see RQ12
        low_r[c]  <= sls_pkg::RST_LIMIT;  // see RQ13
        high_r[c] <= sls_pkg::RST_LIMIT;  // see RQ14
        hyst_r[c] <= sls_pkg::RST_HYST;  // see RQ15
      end else if (wr_ch == 1'(c)) begin
        if (wr_ctrl) begin
          func_r[c] <= wd[sls_pkg::FUNC_LSB +: 3];
          act_r[c]  <= wd[sls_pkg::ACT_LSB +: 2];
        end
        if (wr_filt) tc_r[c] <= tc_in;  // see RQ12
        if (wr_low) low_r[c] <= lim_in;  // see RQ13
        if (wr_high) high_r[c] <= lim_in;  // see RQ14
        if (wr_hyst) hyst_r[c] <= hyst_in;  // see RQ15
      end
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  logic [31:0] value_in [2];  // Monitored inputs
  logic [31:0] filt     [2];  // Filtered values
  logic [1:0]  cond;          // Supervision status
  assign value_in[0] = i_value0;
  assign value_in[1] = i_value1;

  for (genvar g = 0; g < 2; g++) begin : g_ch
    sup_channel u_ch (  // see RQ17
      .i_clock    (i_clock),
      .i_rst_n    (i_rst_n),
      .i_tick     (tick_r),
      .i_value    (value_in[g]),
      .i_mode     (func_r[g]),
      .i_tc       (tc_r[g]),
      .i_low      (low_r[g]),
      .i_high     (high_r[g]),
      .i_hyst     (hyst_r[g]),
      .o_filtered (filt[g]),
      .o_cond     (cond[g])
    );
  end

  // ----------------------------------------
  // Actions
  // ----------------------------------------
  // Status is taken before the action is looked at
  logic [1:0] warn_lvl;   // Warning active
  logic [1:0] fault_set;  // Fault condition
  logic [1:0] warn_rise;  // New warning
  logic [1:0] fault_rise; // New trip
  logic [1:0] fault_nxt;
  logic [3:0] event_nxt;
  for (genvar g = 0; g < 2; g++) begin : g_act
    assign warn_lvl[g]  = cond[g] & (act_r[g] == sls_pkg::ACT_WARN);  // see RQ8 see RQ9
    assign fault_set[g] = cond[g] & (act_r[g] == sls_pkg::ACT_FAULT);  // see RQ8 see RQ10
  end
  assign warn_rise  = warn_lvl & ~warn_prev_r;
  assign fault_rise = fault_set & ~fault_r;
  // A trip in the cycle of a clear wins over the clear
  assign fault_nxt  = fault_set | (fault_r & ~(wr_fault ? wd[1:0] : 2'b00));  // see RQ10
  assign event_nxt  = {fault_rise, warn_rise} |
                      (event_r & ~(wr_event ? wd[3:0] : 4'h0));

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      fault_r     <= 2'b00;
      event_r     <= 4'h0;
      mask_r      <= sls_pkg::RST_MASK;
      warn_prev_r <= 2'b00;
    end else begin
      fault_r     <= fault_nxt;
      event_r     <= event_nxt;
      warn_prev_r <= warn_lvl;
      if (wr_mask) mask_r <= wd[3:0];
    end
  end

  // ----------------------------------------
  // Result outputs
  // ----------------------------------------
  // Channel 0 takes the code when both are active
  logic [15:0] warn_code;
  logic [15:0] fault_code;
  assign warn_code  = warn_lvl[0] ? sls_pkg::WARN_CODE0 :  // see RQ9
                      warn_lvl[1] ? sls_pkg::WARN_CODE1 : 16'h0000;
  assign fault_code = fault_nxt[0] ? sls_pkg::FAULT_CODE0 :  // see RQ10
                      fault_nxt[1] ? sls_pkg::FAULT_CODE1 : 16'h0000;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_status     <= 2'b00;
      o_warning    <= 1'b0;
      o_warn_code  <= 16'h0000;
      o_fault      <= 1'b0;
      o_fault_code <= 16'h0000;
      o_irq        <= 1'b0;
    end else begin
      o_status     <= cond;  // see RQ11
      o_warning    <= |warn_lvl;
      o_warn_code  <= warn_code;
      o_fault      <= |fault_nxt;
      o_fault_code <= fault_code;
      o_irq        <= |(event_nxt & mask_r);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Read data is latched in the address phase, so the slave never waits
  logic        rd_ch;       // Channel of read
  logic [4:0]  rd_off;      // Offset in block
  logic [31:0] ch_word;     // Channel register value
  logic [31:0] glb_word;    // Global register value
  logic [31:0] rd_word;     // Final read value
  assign rd_ch  = a_lo[5];
  assign rd_off = a_lo[4:0];
  assign ch_word =
    (rd_off == sls_pkg::OFF_CTRL)  ? {26'h0, act_r[rd_ch], 1'b0, func_r[rd_ch]} :
    (rd_off == sls_pkg::OFF_FILT)  ? {16'h0000, tc_r[rd_ch]} :
    (rd_off == sls_pkg::OFF_LOW)   ? low_r[rd_ch] :
    (rd_off == sls_pkg::OFF_HIGH)  ? high_r[rd_ch] :
    (rd_off == sls_pkg::OFF_HYST)  ? hyst_r[rd_ch] :
    (rd_off == sls_pkg::OFF_VALUE) ? filt[rd_ch] : 32'h0000_0000;
  assign glb_word =
    (a_lo == sls_pkg::ADDR_STATUS) ? {30'h0, cond} :
    (a_lo == sls_pkg::ADDR_EVENT)  ? {28'h0, event_r} :
    (a_lo == sls_pkg::ADDR_MASK)   ? {28'h0, mask_r} :
    (a_lo == sls_pkg::ADDR_FAULT)  ? {30'h0, fault_r} : 32'h0000_0000;
  assign rd_word = !addr_high0          ? 32'h0000_0000 :
                   (a_lo[7:6] == 2'b00) ? ch_word : glb_word;

  // Zero-wait, always OKAY
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b0;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (addr_take & ~i_hwrite) o_hrdata <= rd_word;
    end
  end
endmodule

// *** tb/sls_monitor.sv ***
/*
  Port checker of the signal limit supervisor.
  Assumes it is bound into signal_limit_supervisor, one clock domain.
*/
`timescale 1ns/10ps
module sls_monitor (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  // Bus side
  input wire logic        i_hsel,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  // Supervision results
  input wire logic [1:0]  o_status,
  input wire logic        o_warning,
  input wire logic [15:0] o_warn_code,
  input wire logic        o_fault,
  input wire logic [15:0] o_fault_code,
  input wire logic        o_irq
);
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Read address taken this edge
  wire rd_take = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_OKAY: assert property (!o_hresp && ($past(i_rst_n) -> o_hreadyout))
    else $error("bus answer not ready or not okay");
  // Read data only moves when a read is taken
  AST_RD_HOLD: assert property (!rd_take |=> $stable(o_hrdata))
    else $error("read data moved without a read");
  AST_WARN_CODE: assert property (o_warning |-> o_warn_code inside {16'hA8B2, 16'hA8B3})
    else $error("warning code wrong");
  AST_NO_WARN: assert property (!o_warning |-> o_warn_code == 16'h0000)
    else $error("warning code without warning");
  AST_WARN_CH0: assert property (o_warn_code == 16'hA8B2 |-> o_status[0])
    else $error("channel 0 warning without condition");
  AST_WARN_CH1: assert property (o_warn_code == 16'hA8B3 |-> o_status[1])
    else $error("channel 1 warning without condition");
  AST_FAULT_CODE: assert property (o_fault ? o_fault_code inside {16'h80B2, 16'h80B3}
    : o_fault_code == 16'h0000) else $error("fault code wrong");
  // A trip needs a live condition
  AST_TRIP: assert property ($rose(o_fault) |-> o_status != 2'h0)
    else $error("fault tripped without condition");
  // Latched fault only leaves through a bus write
  AST_LATCH: assert property ((!i_hsel) [*4] ##0 o_fault |=> o_fault)
    else $error("fault latch dropped on its own");
endmodule

bind signal_limit_supervisor sls_monitor u_mon (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
  .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_status(o_status), .o_warning(o_warning), .o_warn_code(o_warn_code),
  .o_fault(o_fault), .o_fault_code(o_fault_code), .o_irq(o_irq));

// *** tb/sls_source.sv ***
/*
  Signal source model feeding the monitored values.
  Assumes the bench sets wanted values on the same clock.
*/
`timescale 1ns/10ps
module sls_source (
  // Clock
  input  wire logic        i_clock,
  // Wanted values
  input  wire logic [31:0] i_want0,
  input  wire logic [31:0] i_want1,
  // Monitored values
  output logic [31:0]      o_value0,
  output logic [31:0]      o_value1
);
  // One register stage, like a real producer on this clock
  always_ff @(posedge i_clock) begin
    o_value0 <= i_want0;
    o_value1 <= i_want1;
  end
endmodule

// *** tb/testbench.sv ***
/*
  Self-checking bench of the signal limit supervisor.
  Assumes sls_source drives the values and one AHB-Lite master.
*/
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        i_clock = 1'b0;  // 125 MHz
  logic        i_rst_n = 1'b0;
  logic        hsel = 1'b0;     // Master outputs
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] want0 = 32'h0;   // Source setpoints
  logic [31:0] want1 = 32'h0;
  logic [31:0] val0, val1, hrdata, rd;
  logic        hready, hresp, warn, fault, irq;
  logic [1:0]  status;
  logic [15:0] wcode, fcode;
  int          err_total = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #4 i_clock = ~i_clock;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  // Short filter count keeps the run brief
  signal_limit_supervisor #(.TICK_CYCLES(4)) u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_value0(val0), .i_value1(val1),
    .o_status(status), .o_warning(warn), .o_warn_code(wcode), .o_fault(fault),
    .o_fault_code(fcode), .o_irq(irq));
  sls_source u_src (.i_clock(i_clock), .i_want0(want0), .i_want1(want1),
    .o_value0(val0), .o_value1(val1));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Hang guard
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // One single transfer; read data lands in rd
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge i_clock);
    while (hready !== 1'b1) @(posedge i_clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_clock);
    while (hready !== 1'b1) @(posedge i_clock);
    rd = hrdata;
  endtask
  // Channel settings: control written last
  task automatic cfg(input logic [7:0] b, input logic [5:0] c, input logic [31:0] lo, hi, hy);
    xfer(b + 8'h08, 1'b1, lo);
    xfer(b + 8'h0C, 1'b1, hi);
    xfer(b + 8'h10, 1'b1, hy);
    xfer(b, 1'b1, {26'h0, c});
  endtask
  task automatic sv(input logic [31:0] v);
    want0 <= v;
    tick(6);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [7:0] regs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24, 8'h30, 8'h48};
    chk({status, warn, fault, irq}, 32'h0);
    xfer(32'h100, 1'b1, 32'hFFFF_FFFF);  // Unmapped place
    foreach (regs[i]) begin
      xfer(regs[i], 1'b0, 32'h0);
      chk(rd, 32'h0);
    end
    xfer(32'h100, 1'b0, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_limits;
    logic [71:0] lt [5] = '{72'h04_0000FFFF_00007530, 72'h08_7FFFFFFF_7FFFFFD0,
      72'h0C_80000000_80000030, 72'h10_FFFFFFFF_00000000, 72'h04_00000000_00000000};
    foreach (lt[i]) begin
      xfer(lt[i][71:64], 1'b1, lt[i][63:32]);
      xfer(lt[i][71:64], 1'b0, 32'h0);
      chk(rd, lt[i][31:0]);
    end
  endtask
  // Every mode code; top nibble is expected status and mode
  task automatic t_modes;
    logic [35:0] tv [15] = '{36'h0FFFFFE0C, 36'h9FFFFFF6A, 36'h1FFFFFFCE, 36'hA000000FA,
      36'h200000096, 36'hBFFFFFFCE, 36'h300000096, 36'hCFFFFFF06, 36'h4FFFFFF6A,
      36'hDFFFFFF6A, 36'hD000000FA, 36'h500000032, 36'hEFFFFFFCE, 36'h600000096,
      36'hEFFFFFF06};
    cfg(8'h00, 6'h00, 32'hFFFFFF9C, 32'h000000C8, 32'h0);  // Low -1.00, high 2.00
    foreach (tv[i]) begin
      xfer(8'h00, 1'b1, {29'h0, tv[i][34:32]});
      sv(tv[i][31:0]);
      chk(status[0], tv[i][35]);
      chk(warn | fault, 1'b0);
    end
  endtask
  task automatic t_action;
    xfer(8'h48, 1'b1, 32'h4);  // Only the channel 0 fault event unmasked
    cfg(8'h00, 6'h11, 32'h64, 32'h0, 32'h0);
    sv(32'h32);
    chk({status[0], warn, wcode, irq}, {1'b1, 1'b1, 16'hA8B2, 1'b0});
    xfer(8'h48, 1'b1, 32'h5);
    tick(2);
    chk(irq, 1'b1);
    xfer(8'h44, 1'b1, 32'h1);  // Clear warning event
    tick(2);
    chk(irq, 1'b0);
    xfer(8'h00, 1'b1, 32'h21);
    tick(4);
    chk({status[0], warn, fault, fcode}, {3'h5, 16'h80B2});
    xfer(8'h4C, 1'b1, 32'h1);  // Clear refused while condition holds
    sv(32'h1F4);
    chk({status[0], fault, irq}, 3'h3);
    xfer(8'h4C, 1'b1, 32'h1);
    xfer(8'h44, 1'b1, 32'hF);
    tick(2);
    chk({fault, fcode, irq}, 32'h0);
  endtask
  task automatic t_hyst;
    logic [31:0] hv [4] = '{32'h41A, 32'h3B6, 32'h383, 32'h3B6};
    cfg(8'h00, 6'h02, 32'h0, 32'h3E8, 32'h64);  // High 10.00, band 1.00
    foreach (hv[i]) begin
      sv(hv[i]);
      chk(status[0], i < 2);
    end
  endtask
  task automatic t_filter;
    sv(32'h1234);
    xfer(8'h14, 1'b0, 32'h0);
    chk(rd, 32'h1234);
    xfer(8'h04, 1'b1, 32'h4);
    want0 <= 32'h190;
    tick(2);
    xfer(8'h14, 1'b0, 32'h0);
    chk(rd === 32'h1234 || rd === 32'hE0B, 1'b1);
    tick(400);
    xfer(8'h14, 1'b0, 32'h0);
    chk(rd, 32'h190);
    xfer(8'h04, 1'b1, 32'h0);
  endtask
  task automatic t_ch1;
    cfg(8'h20, 6'h22, 32'h0, 32'h64, 32'h0);
    want1 <= 32'hC8;
    tick(6);
    chk({status, fault, fcode}, {3'h5, 16'h80B3});
    xfer(8'h20, 1'b1, 32'h12);
    xfer(8'h4C, 1'b0, 32'h0);
    chk({wcode, rd[15:0]}, 32'hA8B3_0002);
    want1 <= 32'h0;
    tick(6);
    xfer(8'h4C, 1'b1, 32'h2);
    tick(2);
    chk({status[1], fault}, 2'h0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'b1;
    tick(2);
    t_reset();
    t_limits();
    t_modes();
    t_action();
    t_hyst();
    t_filter();
    t_ch1();
    end_of_test();
  end
endmodule
